// file: rx_dma_pkg.sv
// Shared constants for the receive scatter-gather DMA and its host end.
package rx_dma_pkg;
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 32;
   localparam int REG_AW   = 12;
   localparam int REG_DW   = 16;
   localparam int CH_W     = 6;
   localparam int NUM_CH   = 40;
   localparam int SIZE_W   = 13;
   localparam int CNT_W    = SIZE_W + 1;
   localparam int PTR_W    = 16;
   localparam int BYTES_W  = 3;
   localparam int NUM_REG  = 22;
   localparam int APB_AW   = 16;

   // Register indexes; REG_OFS lists the offsets in reverse order, highest index first.
   localparam int I_FQB_LO = 0;
   localparam int I_FQB_HI = 1;
   localparam int I_FQ_END = 2;
   localparam int I_FQ_SML = 3;
   localparam int I_FL_WP  = 4;
   localparam int I_FS_WP  = 5;
   localparam int I_FL_RP  = 6;
   localparam int I_FS_RP  = 7;
   localparam int I_DQB_LO = 8;
   localparam int I_DQB_HI = 9;
   localparam int I_DQ_END = 10;
   localparam int I_DQ_RP  = 11;
   localparam int I_DQ_WP  = 12;
   localparam int I_DQ_FFT = 13;
   localparam int I_DB_LO  = 14;
   localparam int I_DB_HI  = 15;
   localparam int I_CC_SEL = 16;
   localparam int I_CC_DAT = 17;
   localparam int I_QCTL   = 18;
   localparam int I_LBS    = 19;
   localparam int I_SBS    = 20;
   localparam int I_ENG    = 21;
   localparam logic [NUM_REG-1:0][REG_AW-1:0] REG_OFS = {
      12'h7A0, 12'h794, 12'h790, 12'h780, 12'h774, 12'h770,
      12'h754, 12'h750, 12'h744, 12'h740, 12'h73C, 12'h738,
      12'h734, 12'h730, 12'h71C, 12'h718, 12'h714, 12'h710,
      12'h70C, 12'h708, 12'h704, 12'h700};
   localparam logic [REG_DW-1:0] REG_RST = 16'h0000;

   // Channel buffer policy codes and control fields.
   localparam int          POL_W      = 2;
   localparam logic [1:0]  POL_LARGE  = 2'h0;
   localparam logic [1:0]  POL_SMALL  = 2'h1;
   localparam logic [1:0]  POL_MIXED  = 2'h2;
   localparam int          THR_W      = 3;
   localparam int          THR_LSB    = 0;
   localparam int          BURST_BIT  = 3;
   localparam int          ENABLE_BIT = 0;

   // Descriptor and queue entry layout.
   localparam int          ST_W       = 3;
   localparam logic [2:0]  BUF_FIRST  = 3'h1;
   localparam logic [2:0]  BUF_MID    = 3'h2;
   localparam logic [2:0]  BUF_LAST   = 3'h4;
   localparam int          BC_LSB     = 16;
   localparam int          ST_LSB     = 29;
   localparam int          TS_LSB     = 8;
   localparam int          DQ_CH_LSB  = 16;
   localparam int          DQ_EOP_BIT = 31;
   localparam int          FQ_SH      = 3;
   localparam int          DESC_SH    = 4;
   localparam int          DQ_SH      = 2;
   localparam int          DWORD_SH   = 2;
   localparam logic [2:0]  WORD_BYTES = 3'h4;

   // Timestamp runs at the clock divided by sixteen.
   localparam int          TS_DIV_W   = 4;
   localparam int          TS_W       = 24;

   // Host end APB map: below MEM_WIN goes to the device registers.
   localparam logic [15:0] MEM_WIN    = 16'h1000;
endpackage

// file: rx_dma_if.sv
// Link between the receive DMA engine and its host end.
`timescale 1ns/1ps
`default_nettype none
interface rx_dma_if;
   import rx_dma_pkg::*;
   logic              reg_req;
   logic              reg_we;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata;
   logic              reg_ack;
   logic [REG_DW-1:0] reg_rdata;
   logic              mem_req;
   logic              mem_we;
   logic              mem_burst;
   logic [ADDR_W-1:0] mem_addr;
   logic [DATA_W-1:0] mem_wdata;
   logic              mem_ack;
   logic [DATA_W-1:0] mem_rdata;

   modport device(input reg_req, reg_we, reg_addr, reg_wdata, mem_ack,
      mem_rdata, output reg_ack, reg_rdata, mem_req, mem_we, mem_burst,
      mem_addr, mem_wdata);
   modport host(output reg_req, reg_we, reg_addr, reg_wdata, mem_ack,
      mem_rdata, input reg_ack, reg_rdata, mem_req, mem_we, mem_burst,
      mem_addr, mem_wdata);
endinterface // rx_dma_if
`default_nettype wire

// file: rx_dma_engine.sv
// Receive scatter-gather DMA engine, the device end of the host link.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Large buffer size is 13-bit host setting.
// R2 - Small buffer size is 13-bit host setting.
// R3 - Per-channel policy: large, small, or small-then-large.
// R4 - FIFO request starts a packet transfer.
// R5 - Policy picks large or small buffer.
// R6 - Fetch free-queue entry for buffer and descriptor.
// R7 - Write packet data into the buffer.
// R8 - Count bytes; full buffer fetches another entry.
// R9 - Write previous descriptor linking to new one.
// R10 - Repeat until the whole packet is stored.
// R11 - Done entry per packet or 1-7 buffers.
// R12 - Descriptor holds buffer address, status, count.
// R13 - Attributes go into the paired free descriptor.
// R14 - Burst mode groups queue accesses.
// R15 - Free queues: host write, engine read pointers.
// R16 - Done queue: engine write, host read pointers.
// R17 - Host keeps free queues replenished.
// R18 - Host polls, then reads done entries.
// R19 - Host walks links, then rechecks done queue.
// R20 - Engine idle until host sets enable.
// R21 - Buffer status one-hot: first, middle, last.
// R22 - Single size: small start equals end.
// R23 - Advance queue pointers, wrap at queue end.
module rx_dma_engine
   import rx_dma_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   rx_dma_if.device                link,
   input  wire logic               fifo_req_i,
   input  wire logic [DATA_W-1:0]  fifo_data_i,
   input  wire logic [CH_W-1:0]    fifo_chan_i,
   input  wire logic               fifo_eop_i,
   input  wire logic [BYTES_W-1:0] fifo_bytes_i,
   output logic                    fifo_pop_o,
   output logic                    busy_o
);

   typedef enum logic [2:0] {
      S_IDLE, S_FQ0, S_FQ1, S_DATA, S_DESC, S_DONE, S_NEXT
   } state_e;

   typedef struct packed {
      state_e                         st;
      logic [NUM_REG-1:0][REG_DW-1:0] regs;
      logic [NUM_CH-1:0][POL_W-1:0]   cfg;
      logic                           reg_ack;
      logic [REG_DW-1:0]              reg_rdata;
      logic                           mreq;
      logic                           mwe;
      logic                           mburst;
      logic [ADDR_W-1:0]              maddr;
      logic [DATA_W-1:0]              mwdata;
      logic                           pop;
      logic                           busy;
      logic [CH_W-1:0]                chan;
      logic [POL_W-1:0]               pol;
      logic                           cur_small;
      logic                           new_small;
      logic                           linked;
      logic                           head;
      logic                           last;
      logic                           grp_open;
      logic [ADDR_W-1:0]              buf_addr;
      logic [ADDR_W-1:0]              new_addr;
      logic [PTR_W-1:0]               desc_ptr;
      logic [PTR_W-1:0]               new_ptr;
      logic [PTR_W-1:0]               grp_ptr;
      logic [CNT_W-1:0]               count;
      logic [THR_W-1:0]               nbuf;
      logic [1:0]                     step;
      logic [TS_DIV_W-1:0]            ts_div;
      logic [TS_W-1:0]                ts;
   } state_s;

   localparam state_s RST = '0;

   state_s r;
   state_s n;

   // Loads one memory request; it is held until the host acknowledges.
   function automatic state_s issue(input state_s s, input logic we,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic b);
      state_s t;
      t = s;
      t.mreq = 1'b1;
      t.mwe = we;
      t.maddr = a;
      t.mwdata = d;
      t.mburst = b;
      return t;
   endfunction

   // Next-state logic for the register port and the transfer sequence.
   always_comb begin
      logic [CH_W-1:0]   sel;
      logic              use_small;
      logic              burst_en;
      logic [THR_W-1:0]  thr;
      logic [SIZE_W-1:0] cur_size;
      logic [CNT_W-1:0]  wbytes;
      logic              full;
      int                rp;
      int                wp;
      logic [PTR_W-1:0]  rp_next;
      logic [PTR_W-1:0]  dq_next;
      logic [ADDR_W-1:0] fq_addr;
      logic [ADDR_W-1:0] d_addr;
      logic [ADDR_W-1:0] dq_addr;
      logic [DATA_W-1:0] d_word;
      logic [ST_W-1:0]   status;
      sel = r.regs[I_CC_SEL][CH_W-1:0];
      burst_en = r.regs[I_QCTL][BURST_BIT];
      thr = r.regs[I_QCTL][THR_LSB+:THR_W];
      use_small = (r.pol == POL_SMALL) ||
                  (r.pol == POL_MIXED && !r.linked); // [R3] [R5]
      cur_size = r.cur_small ? r.regs[I_SBS][SIZE_W-1:0]  // [R2]
                             : r.regs[I_LBS][SIZE_W-1:0]; // [R1]
      wbytes = fifo_eop_i ? CNT_W'(fifo_bytes_i) : CNT_W'(WORD_BYTES);
      full = (r.count != '0) &&
             (r.count + wbytes > CNT_W'(cur_size)); // [R8]
      rp = use_small ? I_FS_RP : I_FL_RP;
      wp = use_small ? I_FS_WP : I_FL_WP;
      rp_next = r.regs[rp] + 1'b1;
      // Large entries wrap at the small start, small ones at the end.
      if (!use_small && rp_next == r.regs[I_FQ_SML]) begin
         rp_next = '0; // [R23]
      end else if (use_small && rp_next > r.regs[I_FQ_END]) begin
         rp_next = r.regs[I_FQ_SML]; // [R23]
      end
      dq_next = r.regs[I_DQ_WP] + 1'b1;
      if (dq_next > r.regs[I_DQ_END]) begin
         dq_next = '0; // [R23]
      end
      fq_addr = {r.regs[I_FQB_HI], r.regs[I_FQB_LO]} +
                (ADDR_W'(r.regs[rp]) << FQ_SH);
      d_addr = {r.regs[I_DB_HI], r.regs[I_DB_LO]} +
               (ADDR_W'(r.desc_ptr) << DESC_SH) +
               (ADDR_W'(r.step) << DWORD_SH);
      dq_addr = {r.regs[I_DQB_HI], r.regs[I_DQB_LO]} +
                (ADDR_W'(r.regs[I_DQ_WP]) << DQ_SH);
      status = r.last ? BUF_LAST : (r.head ? BUF_FIRST : BUF_MID); // [R21]
      d_word = '0;

      n = r;
      n.reg_ack = 1'b0;
      n.pop = 1'b0;
      n.busy = (r.st != S_IDLE);
      n.ts_div = r.ts_div + 1'b1;
      if (&r.ts_div) begin
         n.ts = r.ts + 1'b1;
      end

      // Register port; the engine's own updates below take priority.
      if (link.reg_req && !r.reg_ack) begin
         n.reg_ack = 1'b1;
         n.reg_rdata = '0;
         for (int i = 0; i < NUM_REG; i++) begin
            if (link.reg_addr == REG_OFS[i]) begin
               n.reg_rdata = r.regs[i];
               if (link.reg_we) begin
                  n.regs[i] = link.reg_wdata;
               end
            end
         end
         if (link.reg_addr == REG_OFS[I_CC_DAT] && int'(sel) < NUM_CH) begin
            n.reg_rdata = REG_DW'(r.cfg[sel]);
            if (link.reg_we) begin
               n.cfg[sel] = link.reg_wdata[POL_W-1:0]; // [R3]
            end
         end
      end

      case (r.st)
         S_IDLE: begin
            if (r.regs[I_ENG][ENABLE_BIT] && fifo_req_i) begin // [R20] [R4]
               n.chan = fifo_chan_i;
               n.pol = (int'(fifo_chan_i) < NUM_CH) ? r.cfg[fifo_chan_i]
                                                     : POL_LARGE;
               n.head = 1'b1;
               n.linked = 1'b0;
               n.st = S_FQ0;
            end
         end
         S_FQ0: begin
            if (!r.mreq) begin
               if (r.regs[rp] != r.regs[wp]) begin // [R15]
                  n = issue(n, 1'b0, fq_addr, d_word, burst_en); // [R6] [R14]
               end
            end else if (link.mem_ack) begin
               n.mreq = 1'b0;
               n.new_addr = link.mem_rdata;
               n.new_small = use_small; // [R5]
               n.st = S_FQ1;
            end
         end
         S_FQ1: begin
            if (!r.mreq) begin
               n = issue(n, 1'b0, fq_addr + (ADDR_W'(1) << DWORD_SH),
                         d_word, 1'b0); // [R6]
            end else if (link.mem_ack) begin
               n.mreq = 1'b0;
               n.new_ptr = link.mem_rdata[PTR_W-1:0];
               n.regs[rp] = rp_next; // [R15] [R23]
               n.st = r.linked ? S_DESC : S_NEXT; // [R9]
               n.step = '0;
            end
         end
         S_DATA: begin
            if (!r.mreq) begin
               if (fifo_req_i && full) begin
                  n.st = S_FQ0; // [R8]
               end else if (fifo_req_i) begin
                  n = issue(n, 1'b1, r.buf_addr + ADDR_W'(r.count),
                            fifo_data_i, 1'b0); // [R7]
                  n.pop = 1'b1;
                  n.last = fifo_eop_i;
                  n.count = r.count + wbytes; // [R8]
               end
            end else if (link.mem_ack) begin
               n.mreq = 1'b0;
               if (r.last) begin
                  n.st = S_DESC; // [R10]
                  n.step = '0;
               end
            end
         end
         S_DESC: begin
            // Dword 0 buffer address, 1 status/count/link, 2 stamp/channel.
            if (r.step == 2'h0) begin
               d_word = r.buf_addr; // [R12]
            end else if (r.step == 2'h1) begin
               d_word[PTR_W-1:0] = r.last ? '0 : r.new_ptr; // [R9]
               d_word[BC_LSB+:SIZE_W] = r.count[SIZE_W-1:0]; // [R12]
               d_word[ST_LSB+:ST_W] = status; // [R21]
            end else begin
               d_word[CH_W-1:0] = r.chan;
               d_word[TS_LSB+:TS_W] = r.ts;
            end
            if (!r.mreq) begin
               n = issue(n, 1'b1, d_addr, d_word,
                         burst_en && r.step != 2'h2); // [R13] [R14]
            end else if (link.mem_ack) begin
               n.mreq = 1'b0;
               n.step = r.step + 1'b1;
               if (r.step == 2'h2) begin
                  n.nbuf = (thr == '0) ? '0 : r.nbuf + 1'b1;
                  n.st = (r.last || (thr != '0 && r.nbuf + 1'b1 == thr))
                         ? S_DONE : S_NEXT; // [R11]
               end
            end
         end
         S_DONE: begin
            d_word[PTR_W-1:0] = r.grp_ptr;
            d_word[DQ_CH_LSB+:CH_W] = r.chan;
            d_word[DQ_EOP_BIT] = r.last;
            if (!r.mreq) begin
               if (dq_next != r.regs[I_DQ_RP]) begin // [R16]
                  n = issue(n, 1'b1, dq_addr, d_word, burst_en); // [R11]
               end
            end else if (link.mem_ack) begin
               n.mreq = 1'b0;
               n.regs[I_DQ_WP] = dq_next; // [R16] [R23]
               n.nbuf = '0;
               n.grp_open = 1'b0;
               n.st = S_NEXT;
            end
         end
         S_NEXT: begin
            if (r.last && r.linked && r.step != '0) begin
               n.linked = 1'b0;
               n.last = 1'b0;
               n.st = S_IDLE;
            end else begin
               // Take over the buffer just fetched and keep filling.
               n.head = !r.linked;
               n.linked = 1'b1;
               n.buf_addr = r.new_addr;
               n.desc_ptr = r.new_ptr;
               n.cur_small = r.new_small;
               n.count = '0;
               n.step = '0;
               if (!r.grp_open) begin
                  n.grp_ptr = r.new_ptr;
                  n.grp_open = 1'b1;
               end
               n.st = S_DATA; // [R10]
            end
         end
         default: n.st = S_IDLE;
      endcase
   end

   // All state registers; reset loads the zero constant only.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   // Outputs come straight from the state flops.
   assign link.reg_ack   = r.reg_ack;
   assign link.reg_rdata = r.reg_rdata;
   assign link.mem_req   = r.mreq;
   assign link.mem_we    = r.mwe;
   assign link.mem_burst = r.mburst;
   assign link.mem_addr  = r.maddr;
   assign link.mem_wdata = r.mwdata;
   assign fifo_pop_o     = r.pop;
   assign busy_o         = r.busy;

endmodule // rx_dma_engine
`default_nettype wire

// file: rx_dma_host.sv
// Host end: APB bridge to the device registers and host memory model.
`timescale 1ns/1ps
`default_nettype none
module rx_dma_host
   import rx_dma_pkg::*;
#(
   parameter int MEM_AW = 6
)
(
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   rx_dma_if.host                 link,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [APB_AW-1:0] paddr_i,
   input  wire logic [DATA_W-1:0] pwdata_i,
   output logic      [DATA_W-1:0] prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o
);

   localparam int MEM_WORDS = 1 << MEM_AW;

   typedef struct packed {
      logic [MEM_WORDS-1:0][DATA_W-1:0] mem;
      logic                             mem_ack;
      logic [DATA_W-1:0]                mem_rdata;
      logic                             reg_req;
      logic                             reg_we;
      logic [REG_AW-1:0]                reg_addr;
      logic [REG_DW-1:0]                reg_wdata;
      logic [DATA_W-1:0]                prdata;
      logic                             pready;
   } state_s;

   localparam state_s RST = '0;

   state_s r;
   state_s n;

   // Engine memory traffic wins the memory; APB waits behind it.
   always_comb begin
      logic [MEM_AW-1:0] widx;
      logic [MEM_AW-1:0] aidx;
      logic              dma_hit;
      widx = link.mem_addr[MEM_AW+DWORD_SH-1:DWORD_SH];
      aidx = paddr_i[MEM_AW+DWORD_SH-1:DWORD_SH];
      dma_hit = link.mem_req && !r.mem_ack;
      n = r;
      n.pready = 1'b0;
      n.mem_ack = 1'b0;
      if (dma_hit) begin
         n.mem_ack = 1'b1; // [R7]
         n.mem_rdata = r.mem[widx];
         if (link.mem_we) begin
            n.mem[widx] = link.mem_wdata;
         end
      end
      if (r.reg_req && link.reg_ack) begin
         n.reg_req = 1'b0;
         n.prdata = DATA_W'(link.reg_rdata);
         n.pready = 1'b1;
      end else if (psel_i && penable_i && !r.pready && !r.reg_req) begin
         if (paddr_i < MEM_WIN) begin
            n.reg_req = 1'b1; // [R20]
            n.reg_we = pwrite_i;
            n.reg_addr = paddr_i[REG_AW-1:0];
            n.reg_wdata = pwdata_i[REG_DW-1:0];
         end else if (!dma_hit) begin
            // Software fills free entries and reads done entries here.
            n.prdata = r.mem[aidx]; // [R17] [R18] [R19]
            if (pwrite_i) begin
               n.mem[aidx] = pwdata_i;
               n.prdata = '0;
            end
            n.pready = 1'b1;
         end
      end
   end

   // State registers with asynchronous reset to constants.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   // Link and bus outputs straight from flops; pslverr_o is tied low.
   assign link.mem_ack   = r.mem_ack;
   assign link.mem_rdata = r.mem_rdata;
   assign link.reg_req   = r.reg_req;
   assign link.reg_we    = r.reg_we;
   assign link.reg_addr  = r.reg_addr;
   assign link.reg_wdata = r.reg_wdata;
   assign prdata_o       = r.prdata;
   assign pready_o       = r.pready;
   assign pslverr_o      = 1'b0;

endmodule // rx_dma_host
`default_nettype wire

// file: rx_dma_assertions.sv
// Handshake checks on the link between the receive DMA and its host end.
`timescale 1ns/1ps
`default_nettype none
module rx_dma_assertions
   import rx_dma_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              reset_i,
   input wire logic              reg_req,
   input wire logic              reg_we,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic              reg_ack,
   input wire logic              mem_req,
   input wire logic              mem_we,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [DATA_W-1:0] mem_wdata,
   input wire logic              mem_ack
);
   // One clock domain, so clocking and reset are declared once.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // Register requests are answered one cycle after they are taken.
   AST_REG_ACK_NEXT:
      assert property (reg_req && !reg_ack |=> reg_ack ##1 !reg_ack)
      else $error("register answer late or not a single pulse");
   AST_REG_HOLD:
      assert property (reg_req && !reg_ack |=>
         reg_req && $stable(reg_addr) && $stable(reg_we))
      else $error("register request changed before its answer");
   AST_REG_RELEASE:
      assert property (reg_ack |=> !reg_req)
      else $error("register request kept after its answer");
   AST_REG_CAUSE:
      assert property ($rose(reg_ack) |-> $past(reg_req))
      else $error("register answer without a request");

   // Memory requests hold until the host answers, which takes one cycle.
   AST_MEM_ACK_NEXT:
      assert property (mem_req && !mem_ack |=> mem_ack ##1 !mem_ack)
      else $error("memory answer late or not a single pulse");
   AST_MEM_HOLD:
      assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
         && $stable(mem_wdata) && $stable(mem_we))
      else $error("memory request changed before its answer");
   AST_MEM_RELEASE:
      assert property (mem_ack |=> !mem_req)
      else $error("memory request kept after its answer");
   AST_MEM_ALIGN:
      assert property (mem_req |-> mem_addr[DWORD_SH-1:0] == '0)
      else $error("memory address not word aligned");
endmodule // rx_dma_assertions
`default_nettype wire

// file: receive_scatter_gather_dma_bench.sv
// Self-checking bench for the receive DMA engine joined to its host end.
`timescale 1ns/1ps
`default_nettype none
module receive_scatter_gather_dma_bench
   import rx_dma_pkg::*;
;
   logic               clk_i      = 1'b0;
   logic               reset_i    = 1'b1;
   logic               psel       = 1'b0;
   logic               penable    = 1'b0;
   logic               pwrite     = 1'b0;
   logic [APB_AW-1:0]  paddr      = '0;
   logic [DATA_W-1:0]  pwdata     = '0;
   logic [DATA_W-1:0]  prdata;
   logic               pready;
   logic               pslverr;
   logic               fifo_req   = 1'b0;
   logic [DATA_W-1:0]  fifo_data  = 32'hA1B2C3D4;
   logic [CH_W-1:0]    fifo_chan  = 6'h05;
   logic               fifo_eop   = 1'b0;
   logic [BYTES_W-1:0] fifo_bytes = 3'h4;
   logic               fifo_pop;
   logic               busy;
   logic [DATA_W-1:0]  rd;
   int                 mismatches = 0;
   int                 num_checks = 0;
   // Free entries, queue layout and sizes; pointers sit one short of a wrap.
   logic [47:0] cfg [23] = '{48'h1008_000000D0, 48'h100C_00000001,
      48'h1018_000000C0, 48'h101C_00000002, 48'h0700_00000000,
      48'h0704_00000000, 48'h0708_00000003, 48'h070C_00000002,
      48'h0710_00000000, 48'h0714_00000002, 48'h0718_00000001,
      48'h071C_00000003, 48'h0730_00000080, 48'h0734_00000000,
      48'h0738_00000003, 48'h073C_00000001, 48'h0740_00000003,
      48'h0750_00000040, 48'h0754_00000000, 48'h0790_00000008,
      48'h0794_00000004, 48'h0770_00000005, 48'h0780_00000008};
   // Second packet uses large buffers only and reports every buffer.
   logic [47:0] cfg2 [8] = '{48'h1000_000000E0, 48'h1004_00000003,
      48'h070C_00000003, 48'h0710_00000002, 48'h073C_00000003,
      48'h0790_00000004, 48'h0774_00000000, 48'h0780_00000009};
   logic [79:0] res2 [9] = '{
      80'h10E0_FFFFFFFF_01020304,
      80'h10D0_0000FFFF_00000506,
      80'h1070_FFFFFFFF_000000E0,
      80'h1074_FFFFFFFF_20040001,
      80'h1054_FFFF0000_80020000,
      80'h1080_803FFFFF_00050003,
      80'h1084_803FFFFF_80050001,
      80'h0718_0000FFFF_00000002,
      80'h0740_0000FFFF_00000002};
   // Address, mask and expected value after one three-word packet.
   logic [79:0] res [12] = '{
      80'h10C0_FFFFFFFF_A1B2C3D4,
      80'h10D0_FFFFFFFF_11223344,
      80'h10D4_0000FFFF_00005566,
      80'h1060_FFFFFFFF_000000C0,
      80'h1064_FFFFFFFF_20040001,
      80'h1068_000000FF_00000005,
      80'h1050_FFFFFFFF_000000D0,
      80'h1054_FFFF0000_80060000,
      80'h108C_803FFFFF_80050002,
      80'h0718_0000FFFF_00000000,
      80'h071C_0000FFFF_00000002,
      80'h0740_0000FFFF_00000000};

   always #25 clk_i = ~clk_i;

   rx_dma_if link ();
   rx_dma_engine rx_dma_engine_inst (.clk_i(clk_i), .reset_i(reset_i),
      .link(link), .fifo_req_i(fifo_req), .fifo_data_i(fifo_data),
      .fifo_chan_i(fifo_chan), .fifo_eop_i(fifo_eop),
      .fifo_bytes_i(fifo_bytes), .fifo_pop_o(fifo_pop), .busy_o(busy));
   rx_dma_host rx_dma_host_inst (.clk_i(clk_i), .reset_i(reset_i),
      .link(link), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr));
   rx_dma_assertions rx_dma_assertions_inst (.clk_i(clk_i),
      .reset_i(reset_i), .reg_req(link.reg_req), .reg_we(link.reg_we),
      .reg_addr(link.reg_addr), .reg_ack(link.reg_ack),
      .mem_req(link.mem_req), .mem_we(link.mem_we),
      .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata),
      .mem_ack(link.mem_ack));

   // One APB transfer; the request is held until pready is seen.
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Offers one FIFO word and returns at the edge that ends its pop.
   task automatic send(input logic [31:0] w, input logic e,
                       input logic [2:0] n);
      fifo_req   <= 1'b1;
      fifo_data  <= w;
      fifo_eop   <= e;
      fifo_bytes <= n;
      @(posedge clk_i);
      while (fifo_pop !== 1'b1) @(posedge clk_i);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // The whole run needs well under a thousand cycles; this cuts a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      test_done();
   end

   // Main sequence: registers, disabled engine, then two chained packets.
   initial begin
      repeat (20) @(posedge clk_i);
      reset_i  <= 1'b0;
      fifo_req <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, 16'h0790 + 16'(4 * i), '0);
         check(rd, '0);
         apb(1'b1, 16'h0790 + 16'(4 * i), 32'h1FFF);
         apb(1'b0, 16'h0790 + 16'(4 * i), '0);
         check(rd, 32'h1FFF);
      end
      apb(1'b1, 16'h07F0, 32'hFFFF);
      apb(1'b0, 16'h07F0, '0);
      check(rd, '0);
      apb(1'b1, 16'h0770, 32'h5);
      for (int p = 0; p < 3; p++) begin
         apb(1'b1, 16'h0774, 32'(p));
         apb(1'b0, 16'h0774, '0);
         check(rd, 32'(p));
      end
      foreach (cfg[i]) apb(1'b1, cfg[i][47:32], cfg[i][31:0]);
      foreach (cfg[i]) begin
         apb(1'b0, cfg[i][47:32], '0);
         check(rd, cfg[i][31:0]);
      end
      $display("test registers done");
      repeat (8) begin
         @(posedge clk_i);
         check({29'h0, pslverr, busy, fifo_pop}, '0);
      end
      apb(1'b1, 16'h07A0, 32'h1);
      send(32'hA1B2C3D4, 1'b0, 3'h4);
      send(32'h11223344, 1'b0, 3'h4);
      send(32'h00005566, 1'b1, 3'h2);
      fifo_req <= 1'b0;
      @(posedge clk_i);
      while (busy !== 1'b0) @(posedge clk_i);
      foreach (res[i]) begin
         apb(1'b0, res[i][79:64], '0);
         check(rd & res[i][63:32], res[i][31:0]);
      end
      $display("test packet done");
      foreach (cfg2[i]) apb(1'b1, cfg2[i][47:32], cfg2[i][31:0]);
      send(32'h01020304, 1'b0, 3'h4);
      send(32'h00000506, 1'b1, 3'h2);
      fifo_req <= 1'b0;
      @(posedge clk_i);
      while (busy !== 1'b0) @(posedge clk_i);
      foreach (res2[i]) begin
         apb(1'b0, res2[i][79:64], '0);
         check(rd & res2[i][63:32], res2[i][31:0]);
      end
      $display("test threshold done");
      test_done();
   end
endmodule // receive_scatter_gather_dma_bench
`default_nettype wire
